// >>> src/qdc_defs.svh
// register offsets, field values and timing counts of the quadrature decoder control block
// Functional notes
// - snap-clear-double task copies double total to snapshot and zeroes it atomically
// - sample-ready flag set on every new motion sample; reads 1 when set
// - report-ready raised after report interval samples when motion total nonzero
// - overflow flag raised when motion or double total would overflow
// - double-step-ready raised after report interval samples when double total nonzero
// - halt-done flag raised once decoder actually stops after a stop request
// - enabled links let report/sample-ready, report-ready, double-step fire snap-clear tasks
// - enabled links let sample, report or double-step events fire the stop task
// - irq enable set: writing 1 enables one of five events; reads enable state
// - irq enable clear: writing 1 disables that event; reads enable state
// - enable field 1 lets decoder own and drive its phase and indicator pins
// - enable field 0 releases the pins to general-purpose use
// - indicator polarity 0 drives LED pin low when lit, 1 drives high
// - sampling interval code 0 is 128 us, each code doubles, code 10 max; the 4-bit field is not clamped and takes codes up to 15
// - a double or illegal transition is reported as sample value 2
// - motion total is 32-bit signed; overflowing samples discarded, overflow flagged
// - report interval codes 0..7 give 10,40..280 samples, code 8 gives one
// - double total saturates at 15; further doubles raise overflow
`ifndef QDC_DEFS_SVH
`define QDC_DEFS_SVH

`define QDC_TASK_START 12'h000
`define QDC_TASK_STOP 12'h004
`define QDC_TASK_CLR_BOTH 12'h008
`define QDC_TASK_CLR_MOTION 12'h00c
`define QDC_TASK_CLR_DOUBLE 12'h010
`define QDC_EV_SAMPLE 12'h100
`define QDC_EV_REPORT 12'h104
`define QDC_EV_OVERFLOW 12'h108
`define QDC_EV_DOUBLE 12'h10c
`define QDC_EV_HALT 12'h110
`define QDC_LINKS 12'h200
`define QDC_IRQ_SET 12'h304
`define QDC_IRQ_CLR 12'h308
`define QDC_ENABLE 12'h500
`define QDC_POLARITY 12'h504
`define QDC_SAMPLING 12'h508
`define QDC_SAMPLE 12'h50c
`define QDC_REPORT 12'h510
`define QDC_MOTION 12'h514
`define QDC_MOTION_SNAP 12'h518
`define QDC_DOUBLE 12'h544
`define QDC_DOUBLE_SNAP 12'h548

`define QDC_NUM_EVENTS 5
`define QDC_NUM_LINKS 7
`define QDC_LINK_RPT_BOTH 0
`define QDC_LINK_SMP_STOP 1
`define QDC_LINK_RPT_MOTION 2
`define QDC_LINK_RPT_STOP 3
`define QDC_LINK_DBL_DOUBLE 4
`define QDC_LINK_DBL_STOP 5
`define QDC_LINK_SMP_BOTH 6

`define QDC_SAMPLING_MAX 4'ha
`define QDC_REPORT_SINGLE_CODE 4'h8
`define QDC_REPORT_FIRST 9'h00a
`define QDC_REPORT_STEP 9'h028
`define QDC_REPORT_SINGLE 9'h001
`define QDC_DOUBLE_MAX 4'hf
`define QDC_SAMPLE_DOUBLE 32'h00000002
`define QDC_SAMPLE_FWD 32'h00000001
`define QDC_SAMPLE_REV 32'hffffffff

`define QDC_CLK_PERIOD_NS 25
`define QDC_SAMPLE_BASE_NS 128000
`define QDC_SAMPLE_BASE_CYCLES (`QDC_SAMPLE_BASE_NS / `QDC_CLK_PERIOD_NS)

`define QDC_RESP_OKAY 2'b00
`define QDC_RESP_SLVERR 2'b10

`endif

// >>> src/qdc_pkg.sv
// types shared by the quadrature decoder control block
package qdc_pkg;
    typedef enum logic [2:0] {
        QDC_EVT_SAMPLE,
        QDC_EVT_REPORT,
        QDC_EVT_OVERFLOW,
        QDC_EVT_DOUBLE,
        QDC_EVT_HALT
    } qdc_event_t;
endpackage

// >>> src/qdc_top.sv
// quadrature decoder control: axi4-lite registers, sampler, totals, events, links
`timescale 1ns/1ps
`include "qdc_defs.svh"
`default_nettype none
module qdc_top
    import qdc_pkg::*;
#(
    parameter int BASE_CYCLES = `QDC_SAMPLE_BASE_CYCLES
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [11:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic phase_a,
    input wire logic phase_b,
    output logic led_out,
    output logic led_oe,
    output logic pins_claimed,
    output logic irq
);
    localparam int NE = `QDC_NUM_EVENTS;
    localparam int NL = `QDC_NUM_LINKS;

    // axi write side
    logic [11:0] wr_addr;
    logic [31:0] wr_data;
    logic wr_go;
    logic wr_hit;
    assign wr_go = !awready && !wready && !bvalid;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            awready <= 1'b1;
            wready <= 1'b1;
            bvalid <= 1'b0;
            bresp <= `QDC_RESP_OKAY;
            wr_addr <= 12'h000;
            wr_data <= 32'h00000000;
        end
        else
        begin
            if (awvalid && awready)
            begin
                wr_addr <= awaddr;
                awready <= 1'b0;
            end
            if (wvalid && wready)
            begin
                wr_data <= wdata;
                wready <= 1'b0;
            end
            if (wr_go)
            begin
                bvalid <= 1'b1;
                bresp <= wr_hit ? `QDC_RESP_OKAY : `QDC_RESP_SLVERR;
                awready <= 1'b1;
                wready <= 1'b1;
            end
            else if (bvalid && bready)
            begin
                bvalid <= 1'b0;
            end
        end
    end

    function automatic logic is_writable(input logic [11:0] a);
        case ({a[11:2], 2'b00})
            `QDC_TASK_START, `QDC_TASK_STOP, `QDC_TASK_CLR_BOTH, `QDC_TASK_CLR_MOTION,
            `QDC_TASK_CLR_DOUBLE, `QDC_EV_SAMPLE, `QDC_EV_REPORT, `QDC_EV_OVERFLOW,
            `QDC_EV_DOUBLE, `QDC_EV_HALT, `QDC_LINKS, `QDC_IRQ_SET, `QDC_IRQ_CLR,
            `QDC_ENABLE, `QDC_POLARITY, `QDC_SAMPLING, `QDC_REPORT:
                is_writable = 1'b1;
            default:
                is_writable = 1'b0;
        endcase
    endfunction

    assign wr_hit = is_writable(wr_addr);

    logic wr_lane0;
    logic [11:0] wr_word;
    logic [3:0] wstrb_q;
    assign wr_lane0 = wr_go && wstrb_q[0];
    assign wr_word = {wr_addr[11:2], 2'b00};
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            wstrb_q <= 4'h0;
        else if (wvalid && wready)
            wstrb_q <= wstrb;
    end

    function automatic logic wr_at(input logic [11:0] w, input logic [11:0] off);
        wr_at = (w == off);
    endfunction

    // task pulses act only on a 1 in bit 0
    logic t_start, t_stop, t_both, t_motion, t_double;
    assign t_start = wr_lane0 && wr_at(wr_word, `QDC_TASK_START) && wr_data[0];
    assign t_stop = wr_lane0 && wr_at(wr_word, `QDC_TASK_STOP) && wr_data[0];
    assign t_both = wr_lane0 && wr_at(wr_word, `QDC_TASK_CLR_BOTH) && wr_data[0];
    assign t_motion = wr_lane0 && wr_at(wr_word, `QDC_TASK_CLR_MOTION) && wr_data[0];
    assign t_double = wr_lane0 && wr_at(wr_word, `QDC_TASK_CLR_DOUBLE) && wr_data[0];

    // configuration registers
    logic [NL-1:0] links;
    logic [NE-1:0] irq_en;
    logic enable;
    logic polarity;
    logic [3:0] sampling;
    logic [3:0] report_code;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            links <= '0;
            enable <= 1'b0;
            polarity <= 1'b0;
            sampling <= 4'h0;
            report_code <= 4'h0;
        end
        else if (wr_lane0)
        begin
            if (wr_at(wr_word, `QDC_LINKS))
                links <= wr_data[NL-1:0];
            if (wr_at(wr_word, `QDC_ENABLE))
                enable <= wr_data[0];
            if (wr_at(wr_word, `QDC_POLARITY))
                polarity <= wr_data[0];
            if (wr_at(wr_word, `QDC_SAMPLING))
                sampling <= wr_data[3:0];
            if (wr_at(wr_word, `QDC_REPORT))
                report_code <= wr_data[3:0];
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            irq_en <= '0;
        else if (wr_lane0 && wr_at(wr_word, `QDC_IRQ_SET))
            irq_en <= irq_en | wr_data[NE-1:0];
        else if (wr_lane0 && wr_at(wr_word, `QDC_IRQ_CLR))
            irq_en <= irq_en & ~wr_data[NE-1:0];
    end

    // phase inputs: three flops, change accepted when second and third agree
    logic [1:0] ab_s1, ab_s2, ab_s3, ab_q;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ab_s1 <= 2'b00;
            ab_s2 <= 2'b00;
            ab_s3 <= 2'b00;
            ab_q <= 2'b00;
        end
        else
        begin
            ab_s1 <= {phase_a, phase_b};
            ab_s2 <= ab_s1;
            ab_s3 <= ab_s2;
            if (ab_s2 == ab_s3)
                ab_q <= ab_s3;
        end
    end

    // sample period tick
    logic running;
    logic [23:0] tick_cnt;
    logic [23:0] period;
    logic tick;
    assign period = 24'(BASE_CYCLES) << sampling;
    assign tick = enable && running && (tick_cnt >= period - 24'h000001);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            tick_cnt <= 24'h000000;
        else if (!enable || !running || tick)
            tick_cnt <= 24'h000000;
        else
            tick_cnt <= tick_cnt + 24'h000001;
    end

    // gray position to step count
    logic [1:0] prev_pos, cur_pos, step;
    logic [31:0] next_sample;
    assign cur_pos = {ab_q[1], ab_q[1] ^ ab_q[0]};
    assign step = cur_pos - prev_pos;

    always_comb
    begin
        case (step)
            2'd0: next_sample = 32'h00000000;
            2'd1: next_sample = `QDC_SAMPLE_FWD;
            2'd3: next_sample = `QDC_SAMPLE_REV;
            default: next_sample = `QDC_SAMPLE_DOUBLE;
        endcase
    end

    logic [31:0] sample_value;
    logic smp_dbl, smp_move;
    assign smp_dbl = (step == 2'd2);
    assign smp_move = step[0];

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            prev_pos <= 2'b00;
            sample_value <= 32'h00000000;
        end
        else if (enable && !running)
            prev_pos <= cur_pos;
        else if (tick)
        begin
            prev_pos <= cur_pos;
            sample_value <= next_sample;
        end
    end

    // snap-clear requests from tasks and registered link pulses
    logic lk_both, lk_motion, lk_double, lk_stop;
    logic clr_motion, clr_double;
    assign clr_motion = t_both || t_motion || lk_both || lk_motion;
    assign clr_double = t_both || t_double || lk_both || lk_double;

    // totals
    logic signed [31:0] motion_total, motion_snap;
    logic [3:0] double_total, double_snap;
    logic signed [31:0] motion_base, next_motion;
    logic [3:0] double_base, next_double;
    logic motion_ovf, double_ovf;

    always_comb
    begin
        motion_base = clr_motion ? 32'sh00000000 : motion_total;
        double_base = clr_double ? 4'h0 : double_total;
        next_motion = motion_base;
        next_double = double_base;
        motion_ovf = 1'b0;
        double_ovf = 1'b0;
        if (tick && smp_move)
        begin
            if ((next_sample == `QDC_SAMPLE_FWD && motion_base == 32'sh7fffffff) ||
                (next_sample == `QDC_SAMPLE_REV && motion_base == 32'sh80000000))
                motion_ovf = 1'b1;
            else
                next_motion = motion_base + $signed(next_sample);
        end
        if (tick && smp_dbl)
        begin
            if (double_base == `QDC_DOUBLE_MAX)
                double_ovf = 1'b1;
            else
                next_double = double_base + 4'h1;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            motion_total <= 32'sh00000000;
            double_total <= 4'h0;
            motion_snap <= 32'sh00000000;
            double_snap <= 4'h0;
        end
        else
        begin
            motion_total <= next_motion;
            double_total <= next_double;
            if (clr_motion)
                motion_snap <= motion_total;
            if (clr_double)
                double_snap <= double_total;
        end
    end

    // samples per report
    logic [8:0] report_len, smp_count;
    logic report_due;
    always_comb
    begin
        if (report_code == `QDC_REPORT_SINGLE_CODE)
            report_len = `QDC_REPORT_SINGLE;
        else if (report_code == 4'h0)
            report_len = `QDC_REPORT_FIRST;
        else
            report_len = 9'(`QDC_REPORT_STEP * report_code);
    end
    assign report_due = tick && (smp_count + 9'h001 >= report_len);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            smp_count <= 9'h000;
        else if (report_due)
            smp_count <= 9'h000;
        else if (tick)
            smp_count <= smp_count + 9'h001;
    end

    // run control
    logic stop_req, halt_set;
    assign stop_req = t_stop || lk_stop;
    assign halt_set = stop_req && running;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            running <= 1'b0;
        else if (stop_req)
            running <= 1'b0;
        else if (t_start)
            running <= 1'b1;
    end

    // event flags, set wins over software write
    logic [NE-1:0] ev, ev_set, ev_wr, ev_val;
    assign ev_set[QDC_EVT_SAMPLE] = tick;
    assign ev_set[QDC_EVT_REPORT] = report_due && (next_motion != 32'sh00000000);
    assign ev_set[QDC_EVT_OVERFLOW] = motion_ovf || double_ovf;
    assign ev_set[QDC_EVT_DOUBLE] = report_due && (next_double != 4'h0);
    assign ev_set[QDC_EVT_HALT] = halt_set;

    always_comb
    begin
        ev_wr = '0;
        ev_val = ev;
        for (int i = 0; i < NE; i++)
        begin
            if (wr_lane0 && wr_word == `QDC_EV_SAMPLE + 12'(4 * i))
            begin
                ev_wr[i] = 1'b1;
                ev_val[i] = wr_data[0];
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            ev <= '0;
        else
            ev <= ev_set | ev_val;
    end

    // event to task links, one cycle after the event
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            lk_both <= 1'b0;
            lk_motion <= 1'b0;
            lk_double <= 1'b0;
            lk_stop <= 1'b0;
        end
        else
        begin
            lk_both <= (ev_set[QDC_EVT_REPORT] && links[`QDC_LINK_RPT_BOTH]) ||
                (ev_set[QDC_EVT_SAMPLE] && links[`QDC_LINK_SMP_BOTH]);
            lk_motion <= ev_set[QDC_EVT_REPORT] && links[`QDC_LINK_RPT_MOTION];
            lk_double <= ev_set[QDC_EVT_DOUBLE] && links[`QDC_LINK_DBL_DOUBLE];
            lk_stop <= (ev_set[QDC_EVT_SAMPLE] && links[`QDC_LINK_SMP_STOP]) ||
                (ev_set[QDC_EVT_REPORT] && links[`QDC_LINK_RPT_STOP]) ||
                (ev_set[QDC_EVT_DOUBLE] && links[`QDC_LINK_DBL_STOP]);
        end
    end

    // pins and interrupt
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            led_oe <= 1'b0;
            led_out <= 1'b0;
            pins_claimed <= 1'b0;
            irq <= 1'b0;
        end
        else
        begin
            pins_claimed <= enable;
            led_oe <= enable;
            led_out <= (enable && running) ? polarity : ~polarity;
            irq <= |(ev & irq_en);
        end
    end

    // axi read side
    logic [31:0] rd_mux;
    logic rd_hit;
    always_comb
    begin
        rd_mux = 32'h00000000;
        rd_hit = 1'b1;
        case ({araddr[11:2], 2'b00})
            `QDC_TASK_START, `QDC_TASK_STOP, `QDC_TASK_CLR_BOTH, `QDC_TASK_CLR_MOTION,
            `QDC_TASK_CLR_DOUBLE: rd_mux = 32'h00000000;
            `QDC_EV_SAMPLE: rd_mux = {31'h0, ev[QDC_EVT_SAMPLE]};
            `QDC_EV_REPORT: rd_mux = {31'h0, ev[QDC_EVT_REPORT]};
            `QDC_EV_OVERFLOW: rd_mux = {31'h0, ev[QDC_EVT_OVERFLOW]};
            `QDC_EV_DOUBLE: rd_mux = {31'h0, ev[QDC_EVT_DOUBLE]};
            `QDC_EV_HALT: rd_mux = {31'h0, ev[QDC_EVT_HALT]};
            `QDC_LINKS: rd_mux = {25'h0, links};
            `QDC_IRQ_SET, `QDC_IRQ_CLR: rd_mux = {27'h0, irq_en};
            `QDC_ENABLE: rd_mux = {31'h0, enable};
            `QDC_POLARITY: rd_mux = {31'h0, polarity};
            `QDC_SAMPLING: rd_mux = {28'h0, sampling};
            `QDC_SAMPLE: rd_mux = sample_value;
            `QDC_REPORT: rd_mux = {28'h0, report_code};
            `QDC_MOTION: rd_mux = motion_total;
            `QDC_MOTION_SNAP: rd_mux = motion_snap;
            `QDC_DOUBLE: rd_mux = {28'h0, double_total};
            `QDC_DOUBLE_SNAP: rd_mux = {28'h0, double_snap};
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= `QDC_RESP_OKAY;
        end
        else if (arvalid && arready)
        begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= rd_mux;
            rresp <= rd_hit ? `QDC_RESP_OKAY : `QDC_RESP_SLVERR;
        end
        else if (rvalid && rready)
        begin
            rvalid <= 1'b0;
            arready <= 1'b1;
        end
    end

    // checks
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    a_double_snap_clear: assert property (t_double && !tick && !lk_both |=>
        double_snap == $past(double_total) && double_total == 4'h0)
        else $error("double snapshot or clear wrong");
    a_sample_flag_set: assert property (tick |=> ev[QDC_EVT_SAMPLE] ##0
        sample_value == $past(next_sample))
        else $error("sample flag not raised");
    a_report_nonzero: assert property (ev_set[QDC_EVT_REPORT] |=>
        motion_total != 32'sh00000000 && ev[QDC_EVT_REPORT])
        else $error("report raised on zero total");
    a_overflow_flag: assert property (motion_ovf |=>
        ev[QDC_EVT_OVERFLOW] && motion_total == $past(motion_base))
        else $error("overflow not flagged or sample kept");
    a_double_nonzero: assert property (ev_set[QDC_EVT_DOUBLE] |=> double_total != 4'h0)
        else $error("double event on zero total");
    a_halt_flag: assert property (halt_set |=> !running && ev[QDC_EVT_HALT])
        else $error("halt not flagged");
    a_link_stop: assert property (ev_set[QDC_EVT_SAMPLE] && links[`QDC_LINK_SMP_STOP]
        && !t_start |=> ##1 !running)
        else $error("link stop missing");
    a_irq_follow: assert property (|(ev & irq_en) |=> irq)
        else $error("interrupt not raised");
    a_pin_release: assert property (!enable |=> !led_oe && !pins_claimed)
        else $error("pins not released");
    a_double_saturate: assert property (double_total == `QDC_DOUBLE_MAX && tick && smp_dbl
        && !clr_double |=> double_total == `QDC_DOUBLE_MAX && ev[QDC_EVT_OVERFLOW])
        else $error("double total not saturated");
endmodule
`default_nettype wire

// >>> tb/qdc_encoder.sv
// behavioural quadrature encoder driving the two phase lines
`timescale 1ns/1ps
`default_nettype none
module qdc_encoder
(
    input wire logic aclk,
    output logic phase_a,
    output logic phase_b
);
    logic [1:0] pos = 2'h0;
    logic [1:0] gray;
    // forward order 00,01,11,10
    assign gray = pos ^ {1'b0, pos[1]};
    assign phase_a = gray[1];
    assign phase_b = gray[0];
    // n=1 forward, n=3 reverse, n=2 a double jump; held well past one sample tick
    task automatic step(input logic [1:0] n);
        begin
            @(posedge aclk);
            pos <= pos + n;
            repeat (20) @(posedge aclk);
        end
    endtask
endmodule
`default_nettype wire

// >>> tb/testbench.sv
// register-level bench of the quadrature decoder control block
`timescale 1ns/1ps
`include "qdc_defs.svh"
`default_nettype none
module testbench
    import qdc_pkg::*;
;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, d, rdata_w;
    logic [3:0] wstrb;
    logic awready, wready, bvalid, arready, rvalid, phase_a, phase_b;
    logic led_out, led_oe, pins_claimed, irq;
    logic [1:0] bresp, rresp, r;
    logic [11:0] zero_regs [12] = '{`QDC_EV_SAMPLE, `QDC_EV_REPORT, `QDC_EV_OVERFLOW,
        `QDC_EV_DOUBLE, `QDC_EV_HALT, `QDC_IRQ_SET, `QDC_IRQ_CLR, `QDC_ENABLE,
        `QDC_POLARITY, `QDC_SAMPLING, `QDC_SAMPLE, `QDC_TASK_CLR_BOTH};
    int fail_count = 0;
    int comparisons = 0;
    int cyc = 0;
    int t0;
    qdc_top #(.BASE_CYCLES(8)) dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata_w), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .phase_a(phase_a), .phase_b(phase_b), .led_out(led_out),
        .led_oe(led_oe), .pins_claimed(pins_claimed), .irq(irq));
    qdc_encoder enc (.aclk(aclk), .phase_a(phase_a), .phase_b(phase_b));
    initial
    begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end
    always @(posedge aclk) cyc <= cyc + 1;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("Error at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out;
        $display("mismatches %0d comparisons %0d", fail_count, comparisons);
        if (fail_count == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end
        while (bvalid !== 1'b1);
        bready <= 1'b0;
    endtask
    task automatic rc(input logic [11:0] a, input logic [31:0] exp);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end
        while (rvalid !== 1'b1);
        d = rdata_w;
        r = rresp;
        rready <= 1'b0;
        chk(d, exp);
    endtask
    task automatic wirq(input logic lv);
        while (irq !== lv) @(posedge aclk);
    endtask
    initial
    begin
        repeat (30000) @(posedge aclk);
        fail_count++;
        close_out();
    end
    initial
    begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
        wstrb = 4'hf;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (zero_regs[i]) rc(zero_regs[i], 32'h0);
        chk({led_oe, pins_claimed, irq}, 32'h0);
        rc(12'h7f0, 32'h0);
        chk(r, `QDC_RESP_SLVERR);
        wr(`QDC_IRQ_SET, 32'h1f);
        rc(`QDC_IRQ_SET, 32'h1f);
        wr(`QDC_IRQ_CLR, 32'h05);
        wr(`QDC_IRQ_SET, 32'h0);
        rc(`QDC_IRQ_CLR, 32'h1a);
        wr(`QDC_IRQ_CLR, 32'h1a);
        wr(`QDC_IRQ_SET, 32'h01);
        wr(`QDC_ENABLE, 32'h1);
        wr(`QDC_POLARITY, 32'h1);
        // lane 0 strobe off: write must not land
        wstrb <= 4'h0;
        wr(`QDC_POLARITY, 32'h0);
        wstrb <= 4'hf;
        rc(`QDC_POLARITY, 32'h1);
        wr(`QDC_REPORT, 32'h8);
        wr(`QDC_TASK_START, 32'h1);
        repeat (2) @(posedge aclk);
        chk({pins_claimed, led_oe, led_out}, 32'h7);
        for (int c = 0; c < 3; c++)
        begin
            // stopped: no tick can race the flag clear, count restarts at start
            wr(`QDC_TASK_STOP, 32'h1);
            wr(`QDC_SAMPLING, c);
            wr(`QDC_EV_SAMPLE, 32'h0);
            wirq(1'b0);
            wr(`QDC_TASK_START, 32'h1);
            t0 = cyc;
            wirq(1'b1);
            // first tick one period after start, irq one cycle later
            chk(cyc - t0, (8 << c) + 1);
            rc(`QDC_EV_SAMPLE, 32'h1);
        end
        wr(`QDC_IRQ_CLR, 32'h01);
        repeat (2) @(posedge aclk);
        chk(irq, 1'b0);
        wr(`QDC_SAMPLING, 32'h0);
        wr(`QDC_TASK_CLR_BOTH, 32'h1);
        wr(`QDC_EV_REPORT, 32'h0);
        repeat (3) enc.step(2'h1);
        rc(`QDC_MOTION, 32'h3);
        rc(`QDC_EV_REPORT, 32'h1);
        wr(`QDC_TASK_CLR_MOTION, 32'h1);
        rc(`QDC_MOTION_SNAP, 32'h3);
        rc(`QDC_MOTION, 32'h0);
        enc.step(2'h2);
        rc(`QDC_DOUBLE, 32'h1);
        rc(`QDC_EV_DOUBLE, 32'h1);
        wr(`QDC_TASK_CLR_DOUBLE, 32'h0);
        rc(`QDC_DOUBLE, 32'h1);
        rc(`QDC_TASK_CLR_DOUBLE, 32'h0);
        wr(`QDC_TASK_CLR_DOUBLE, 32'h1);
        rc(`QDC_DOUBLE_SNAP, 32'h1);
        rc(`QDC_DOUBLE, 32'h0);
        repeat (15) enc.step(2'h2);
        rc(`QDC_DOUBLE, 32'hf);
        rc(`QDC_EV_OVERFLOW, 32'h0);
        enc.step(2'h2);
        rc(`QDC_DOUBLE, 32'hf);
        rc(`QDC_EV_OVERFLOW, 32'h1);
        wr(`QDC_TASK_CLR_BOTH, 32'h1);
        wr(`QDC_EV_HALT, 32'h0);
        wr(`QDC_LINKS, 32'h30);
        enc.step(2'h2);
        rc(`QDC_EV_HALT, 32'h1);
        rc(`QDC_SAMPLE, `QDC_SAMPLE_DOUBLE);
        rc(`QDC_DOUBLE_SNAP, 32'h1);
        rc(`QDC_DOUBLE, 32'h0);
        chk(led_out, 1'b0);
        rc(`QDC_LINKS, 32'h30);
        wr(`QDC_LINKS, 32'h0);
        rc(`QDC_LINKS, 32'h0);
        wr(`QDC_EV_HALT, 32'h0);
        wr(`QDC_TASK_START, 32'h1);
        wr(`QDC_TASK_STOP, 32'h1);
        rc(`QDC_EV_HALT, 32'h1);
        // sample event stops the decoder through its link
        wr(`QDC_EV_HALT, 32'h0);
        wr(`QDC_LINKS, 32'h02);
        wr(`QDC_TASK_START, 32'h1);
        repeat (12) @(posedge aclk);
        rc(`QDC_EV_HALT, 32'h1);
        chk(led_out, 1'b0);
        wr(`QDC_LINKS, 32'h0);
        wr(`QDC_ENABLE, 32'h0);
        repeat (2) @(posedge aclk);
        chk({led_oe, pins_claimed}, 32'h0);
        close_out();
    end
endmodule
`default_nettype wire
